// ===== qpll_i2c_top.sv
/*
 Serial target front end of the four-PLL clock device: start/stop and
 byte handling, PLL selection from the target address, four register
 maps and per-PLL reset gating of oscillator lock. Assumes SCL and SDA
 arrive as pins (synchronised here) and the board resolves open drain.
*/
`include "qpll_map.svh"

module qpll_i2c_top #(
    parameter int NUM_PLL = `QPLL_NUM_PLL
) (
    input  wire logic       ref_clk,
    input  wire logic       reset,
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    input  wire logic [3:0] pll_reset_n,
    output logic [3:0]      pll_lock_enable,
    output logic [3:0]      pll_free_run,
    output logic [3:0]      pll_bypass,
    output logic [3:0]      pll_freeze
);

    qpll_pkg::qpll_top_state_t s;
    qpll_pkg::qpll_top_state_t next_s;
    logic [3:0][7:0]           rd_all;
    logic [7:0]                rd;
    logic                      scl_rise;
    logic                      scl_fall;
    logic                      start_c;
    logic                      stop_c;
    logic                      byte_done;

    if (NUM_PLL != 4) begin : g_chk
        $error("qpll_i2c_top: two select bits serve exactly four PLLs");
    end

    // Target address upper bits
    function automatic logic addr_match(input logic [7:0] b);
        addr_match = (b[7:3] == `QPLL_ADDR_HI);
    endfunction : addr_match

    // One map per PLL, written only when selected
    for (genvar i = 0; i < 4; i++) begin : g_pll
        qpll_regmap u_map (
            .ref_clk  (ref_clk),
            .reset    (reset),
            .wr_en    (s.wr_en && (s.wr_sel == 2'(i))),
            .addr     (s.wr_en ? s.wr_addr : s.regptr),
            .wdata    (s.wr_data),
            .rdata    (rd_all[i]),
            .free_run (pll_free_run[i]),
            .bypass   (pll_bypass[i]),
            .freeze   (pll_freeze[i])
        );
    end

    assign rd        = rd_all[s.sel];
    assign scl_rise  = s.scl_s2 && !s.scl_d;
    assign scl_fall  = !s.scl_s2 && s.scl_d;
    assign start_c   = s.scl_s2 && s.scl_d && !s.sda_s2 && s.sda_d;
    assign stop_c    = s.scl_s2 && s.scl_d && s.sda_s2 && !s.sda_d;
    assign byte_done = scl_fall && (s.bitcnt == 4'h8);

    always_comb begin
        next_s        = s;
        next_s.scl_s1 = scl_in;
        next_s.scl_s2 = s.scl_s1;
        next_s.scl_d  = s.scl_s2;
        next_s.sda_s1 = sda_in;
        next_s.sda_s2 = s.sda_s1;
        next_s.sda_d  = s.sda_s2;
        next_s.rst_s1 = pll_reset_n;
        next_s.rst_s2 = s.rst_s1;
        next_s.lock_en = s.rst_s2;
        next_s.wr_en  = 1'b0;
        next_s.sda_o  = 1'b0;
        if (start_c) begin
            next_s.st     = qpll_pkg::QPLL_ADDR;
            next_s.bitcnt = 4'h0;
            next_s.sda_oe = 1'b0;
        end else if (stop_c) begin
            next_s.st     = qpll_pkg::QPLL_IDLE;
            next_s.sda_oe = 1'b0;
        end else begin
            unique case (s.st)
                qpll_pkg::QPLL_IDLE: begin
                    next_s.sda_oe = 1'b0;
                end
                qpll_pkg::QPLL_ADDR, qpll_pkg::QPLL_REGA, qpll_pkg::QPLL_WDATA: begin
                    if (scl_rise) begin
                        next_s.shreg  = {s.shreg[6:0], s.sda_s2};
                        next_s.bitcnt = 4'(s.bitcnt + 4'h1);
                    end else if (byte_done) begin
                        next_s.sda_oe = 1'b1;
                        if (s.st == qpll_pkg::QPLL_ADDR) begin
                            if (addr_match(s.shreg)) begin
                                next_s.sel = s.shreg[2:1];
                                next_s.rw  = s.shreg[0];
                                next_s.st  = qpll_pkg::QPLL_ACK_ADDR;
                            end else begin
                                next_s.sda_oe = 1'b0;
                                next_s.st     = qpll_pkg::QPLL_IDLE;
                            end
                        end else if (s.st == qpll_pkg::QPLL_REGA) begin
                            next_s.regptr = s.shreg;
                            next_s.st     = qpll_pkg::QPLL_ACK_REG;
                        end else begin
                            next_s.wr_en   = 1'b1;
                            next_s.wr_sel  = s.sel;
                            next_s.wr_addr = s.regptr;
                            next_s.wr_data = s.shreg;
                            next_s.regptr  = 8'(s.regptr + 8'h01);
                            next_s.st      = qpll_pkg::QPLL_ACK_WR;
                        end
                    end
                end
                qpll_pkg::QPLL_ACK_ADDR: begin
                    if (scl_fall) begin
                        next_s.bitcnt = 4'h0;
                        if (s.rw) begin
                            next_s.shreg  = rd;
                            next_s.sda_oe = !rd[7];
                            next_s.st     = qpll_pkg::QPLL_RDATA;
                        end else begin
                            next_s.sda_oe = 1'b0;
                            next_s.st     = qpll_pkg::QPLL_REGA;
                        end
                    end
                end
                qpll_pkg::QPLL_ACK_REG, qpll_pkg::QPLL_ACK_WR: begin
                    if (scl_fall) begin
                        next_s.sda_oe = 1'b0;
                        next_s.bitcnt = 4'h0;
                        next_s.st     = qpll_pkg::QPLL_WDATA;
                    end
                end
                qpll_pkg::QPLL_RDATA: begin
                    if (scl_rise) begin
                        next_s.bitcnt = 4'(s.bitcnt + 4'h1);
                    end else if (byte_done) begin
                        next_s.sda_oe = 1'b0;
                        next_s.st     = qpll_pkg::QPLL_ACK_RD;
                    end else if (scl_fall) begin
                        next_s.shreg  = {s.shreg[6:0], 1'b0};
                        next_s.sda_oe = !s.shreg[6];
                    end
                end
                qpll_pkg::QPLL_ACK_RD: begin
                    if (scl_rise) begin
                        if (s.sda_s2) begin
                            next_s.st = qpll_pkg::QPLL_IDLE;
                        end else begin
                            next_s.regptr = 8'(s.regptr + 8'h01);
                            next_s.bitcnt = 4'h9;
                        end
                    end else if (scl_fall && (s.bitcnt == 4'h9)) begin
                        next_s.bitcnt = 4'h0;
                        next_s.shreg  = rd;
                        next_s.sda_oe = !rd[7];
                        next_s.st     = qpll_pkg::QPLL_RDATA;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            s         <= '0;
            s.st      <= qpll_pkg::QPLL_IDLE;
            s.scl_s1  <= 1'b1;
            s.scl_s2  <= 1'b1;
            s.scl_d   <= 1'b1;
            s.sda_s1  <= 1'b1;
            s.sda_s2  <= 1'b1;
            s.sda_d   <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    assign sda_out         = s.sda_o;
    assign sda_oe          = s.sda_oe;
    assign pll_lock_enable = s.lock_en;

    // Checks
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (reset);

    AST_ADDR_MATCH: assert property (
        (s.st == qpll_pkg::QPLL_ADDR && byte_done && s.shreg[7:3] == 5'h1a)
        |=> (s.st == qpll_pkg::QPLL_ACK_ADDR) && sda_oe)
        else $error("matching target address not acknowledged");

    AST_ADDR_MISS: assert property (
        (s.st == qpll_pkg::QPLL_ADDR && byte_done && s.shreg[7:3] != 5'h1a && !start_c)
        |=> (s.st == qpll_pkg::QPLL_IDLE) && !sda_oe)
        else $error("foreign target address acknowledged");

    AST_SELECT: assert property (
        (s.st == qpll_pkg::QPLL_ADDR && byte_done && s.shreg[7:3] == 5'h1a)
        |=> s.sel == $past(s.shreg[2:1]))
        else $error("PLL select not taken from low address bits");

    AST_WRITE_TARGET: assert property (
        (s.st == qpll_pkg::QPLL_WDATA && byte_done && !start_c && !stop_c)
        |=> s.wr_en && (s.wr_sel == s.sel) ##1 !s.wr_en)
        else $error("data byte not written once to selected map");

    AST_RESET_NO_LOCK: assert property (
        (!pll_reset_n[0])[*3] |=> !pll_lock_enable[0])
        else $error("PLL in reset allowed to lock");

    AST_CONFIG_REG: assert property (
        (s.wr_en && s.wr_addr == 8'h00 && s.wr_sel == 2'h1)
        |=> pll_bypass[1] == $past(s.wr_data[1]))
        else $error("run control write did not steer bypass");

    AST_READ_BIT: assert property (
        (s.st == qpll_pkg::QPLL_RDATA && scl_fall && s.bitcnt != 4'h8 && !start_c && !stop_c)
        |=> sda_oe == !$past(s.shreg[6]))
        else $error("read bit driven wrongly");

    AST_ACK_RELEASE: assert property (
        (s.st == qpll_pkg::QPLL_ACK_REG && scl_fall && !start_c && !stop_c)
        |=> !sda_oe && s.st == qpll_pkg::QPLL_WDATA && s.bitcnt == 4'h0)
        else $error("acknowledge not released after register byte");

    AST_LOCK_RELEASE: assert property (
        (pll_reset_n[0])[*3] |=> pll_lock_enable[0])
        else $error("PLL out of reset not allowed to lock");

    for (genvar j = 1; j < 4; j++) begin : g_lock_chk
        AST_RESET_NO_LOCK_N: assert property (@(posedge ref_clk) disable iff (reset)
            (!pll_reset_n[j])[*3] |=> !pll_lock_enable[j])
            else $error("PLL in reset allowed to lock");
    end

    AST_IDLE_QUIET: assert property (
        (s.st == qpll_pkg::QPLL_IDLE)
        |-> !sda_oe)
        else $error("idle target drives the data line");

    AST_START_ADDR: assert property (
        start_c
        |=> (s.st == qpll_pkg::QPLL_ADDR) && (s.bitcnt == 4'h0) && !sda_oe)
        else $error("start did not restart address reception");

    AST_STOP_IDLE: assert property (
        stop_c
        |=> (s.st == qpll_pkg::QPLL_IDLE) && !sda_oe)
        else $error("stop did not return to idle");

    AST_REG_POINTER: assert property (
        (s.st == qpll_pkg::QPLL_REGA && byte_done)
        |=> s.regptr == $past(s.shreg))
        else $error("register address byte not loaded into pointer");

    AST_WRITE_DATA: assert property (
        (s.st == qpll_pkg::QPLL_WDATA && byte_done)
        |=> (s.wr_data == $past(s.shreg)) && (s.wr_addr == $past(s.regptr)))
        else $error("write strobe carries wrong register or data");

    AST_POINTER_STEP: assert property (
        (s.st == qpll_pkg::QPLL_WDATA && byte_done)
        |=> s.regptr == 8'($past(s.regptr) + 8'h01))
        else $error("register pointer did not advance after data byte");

    AST_WRITE_ONLY_ACK: assert property (
        s.wr_en |-> (s.st == qpll_pkg::QPLL_ACK_WR))
        else $error("map write strobe outside a data byte");

    AST_READ_FIRST: assert property (
        (s.st == qpll_pkg::QPLL_ACK_ADDR && scl_fall && s.rw)
        |=> (s.st == qpll_pkg::QPLL_RDATA) && (sda_oe == !$past(rd[7])))
        else $error("first read bit not driven from the selected map");

    AST_READ_RELEASE: assert property (
        (s.st == qpll_pkg::QPLL_RDATA && byte_done)
        |=> (s.st == qpll_pkg::QPLL_ACK_RD) && !sda_oe)
        else $error("data line not released for host acknowledge");

    AST_NACK_IDLE: assert property (
        (s.st == qpll_pkg::QPLL_ACK_RD && scl_rise && s.sda_s2)
        |=> s.st == qpll_pkg::QPLL_IDLE)
        else $error("host not-acknowledge did not end the read");

    AST_ACK_NEXT: assert property (
        (s.st == qpll_pkg::QPLL_ACK_RD && scl_rise && !s.sda_s2)
        |=> s.regptr == 8'($past(s.regptr) + 8'h01))
        else $error("host acknowledge did not advance the pointer");

    COV_WRITE: cover property (s.wr_en && s.wr_sel == 2'h3);
    COV_READ: cover property (s.st == qpll_pkg::QPLL_ACK_RD ##1 s.st == qpll_pkg::QPLL_RDATA);
    COV_MISS: cover property (s.st == qpll_pkg::QPLL_ADDR ##1 s.st == qpll_pkg::QPLL_IDLE);
    COV_ACK_NEXT: cover property (s.st == qpll_pkg::QPLL_ACK_RD && scl_rise && !s.sda_s2);
    COV_LOCK: cover property ($rose(pll_lock_enable[0]));

endmodule : qpll_i2c_top

// ===== qpll_map.svh
/*
 Register offsets, field positions, reset values and address constants
 of the four-PLL configuration front end. Assumes inclusion by bare name.
*/
`ifndef QPLL_MAP_SVH
`define QPLL_MAP_SVH

`define QPLL_ADDR_HI            5'h1a
`define QPLL_NUM_PLL            4
`define QPLL_MAP_DEPTH          25
`define QPLL_REG_RESET          8'h00

`define QPLL_RUN_CONTROL        8'h00
`define QPLL_BANDWIDTH_RATE     8'h02
`define QPLL_FREEZE_SQUELCH     8'h03
`define QPLL_INPUT_FORMAT       8'h05
`define QPLL_OUTPUT_FORMAT      8'h06
`define QPLL_HOLDOVER           8'h08
`define QPLL_OUTPUT_DISABLE     8'h0a
`define QPLL_INPUT_POWERDOWN    8'h0b
`define QPLL_COARSE_LATENCY     8'h10
`define QPLL_FINE_LATENCY_HIGH  8'h11
`define QPLL_FINE_LATENCY_LOW   8'h12
`define QPLL_LOCK_DETECT        8'h13
`define QPLL_ALARM_PIN          8'h14
`define QPLL_PIN_FUNCTION       8'h15
`define QPLL_ALARM_POLARITY     8'h16
`define QPLL_SIGNAL_LOSS_MASK   8'h17
`define QPLL_LOCK_LOSS_MASK     8'h18

`define QPLL_FREE_RUN_BIT       6
`define QPLL_BYPASS_BIT         1
`define QPLL_FREEZE_BIT         5

`endif

// ===== qpll_pkg.sv
/*
 Types of the four-PLL configuration front end.
 Assumes qpll_map.svh is on the include path.
*/
`include "qpll_map.svh"

package qpll_pkg;

    typedef enum logic [3:0] {
        QPLL_IDLE, QPLL_ADDR, QPLL_ACK_ADDR, QPLL_REGA, QPLL_ACK_REG,
        QPLL_WDATA, QPLL_ACK_WR, QPLL_RDATA, QPLL_ACK_RD
    } qpll_state_t;

    typedef struct packed {
        qpll_state_t st;
        logic        scl_s1;
        logic        scl_s2;
        logic        scl_d;
        logic        sda_s1;
        logic        sda_s2;
        logic        sda_d;
        logic [3:0]  rst_s1;
        logic [3:0]  rst_s2;
        logic [3:0]  lock_en;
        logic [7:0]  shreg;
        logic [3:0]  bitcnt;
        logic [1:0]  sel;
        logic        rw;
        logic [7:0]  regptr;
        logic        sda_oe;
        logic        sda_o;
        logic        wr_en;
        logic [1:0]  wr_sel;
        logic [7:0]  wr_addr;
        logic [7:0]  wr_data;
    } qpll_top_state_t;

    typedef struct packed {
        logic [`QPLL_MAP_DEPTH-1:0][7:0] regs;
    } qpll_map_state_t;

endpackage : qpll_pkg

// ===== qpll_regmap.sv
/*
 One PLL's register map: byte registers written by a one-cycle strobe,
 read combinationally. Assumes the strobe comes from logic on ref_clk.
*/
`include "qpll_map.svh"

module qpll_regmap #(
    parameter int DEPTH = `QPLL_MAP_DEPTH
) (
    input  wire logic       ref_clk,
    input  wire logic       reset,
    input  wire logic       wr_en,
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    output logic [7:0]      rdata,
    output logic            free_run,
    output logic            bypass,
    output logic            freeze
);

    qpll_pkg::qpll_map_state_t s;
    qpll_pkg::qpll_map_state_t next_s;

    if (DEPTH != `QPLL_MAP_DEPTH) begin : g_chk
        $error("qpll_regmap: DEPTH must match the map");
    end

    // Listed offsets only
    function automatic logic listed(input logic [7:0] a);
        case (a)
            `QPLL_RUN_CONTROL, `QPLL_BANDWIDTH_RATE, `QPLL_FREEZE_SQUELCH,
            `QPLL_INPUT_FORMAT, `QPLL_OUTPUT_FORMAT, `QPLL_HOLDOVER,
            `QPLL_OUTPUT_DISABLE, `QPLL_INPUT_POWERDOWN, `QPLL_COARSE_LATENCY,
            `QPLL_FINE_LATENCY_HIGH, `QPLL_FINE_LATENCY_LOW, `QPLL_LOCK_DETECT,
            `QPLL_ALARM_PIN, `QPLL_PIN_FUNCTION, `QPLL_ALARM_POLARITY,
            `QPLL_SIGNAL_LOSS_MASK, `QPLL_LOCK_LOSS_MASK: listed = 1'b1;
            default: listed = 1'b0;
        endcase
    endfunction : listed

    always_comb begin
        next_s = s;
        if (wr_en && listed(addr)) begin
            next_s.regs[addr[4:0]] = wdata;
        end
    end

    always_ff @(posedge ref_clk or posedge reset) begin
        if (reset) begin
            s <= {`QPLL_MAP_DEPTH{`QPLL_REG_RESET}};
        end else begin
            s <= next_s;
        end
    end

    assign rdata    = listed(addr) ? s.regs[addr[4:0]] : 8'h00;
    assign free_run = s.regs[`QPLL_RUN_CONTROL][`QPLL_FREE_RUN_BIT];
    assign bypass   = s.regs[`QPLL_RUN_CONTROL][`QPLL_BYPASS_BIT];
    assign freeze   = s.regs[`QPLL_FREEZE_SQUELCH][`QPLL_FREEZE_BIT];

endmodule : qpll_regmap

// ===== qpll_host.sv
/*
 Behavioural serial host for the four-PLL front end: start, stop, byte
 and register access tasks. Assumes a pull-up resolves SDA outside.
*/
`include "qpll_map.svh"

module qpll_host (
    input  wire logic ref_clk,
    input  wire logic sda_line,
    output logic      scl,
    output logic      sda_pull
);
    timeunit 1ns;
    timeprecision 100ps;

    localparam int Q = 10;

    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end

    task automatic wt(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask : wt

    // Also serves as repeated start
    task automatic start_c;
        sda_pull = 1'b0;
        wt(Q);
        scl = 1'b1;
        wt(Q);
        sda_pull = 1'b1;
        wt(Q);
        scl = 1'b0;
        wt(3);
    endtask : start_c

    task automatic stop_c;
        sda_pull = 1'b1;
        wt(Q);
        scl = 1'b1;
        wt(Q);
        sda_pull = 1'b0;
        wt(Q);
    endtask : stop_c

    // Data held until after the clock fall
    task automatic bit_c(input logic b, output logic s);
        sda_pull = !b;
        wt(Q);
        scl = 1'b1;
        wt(Q / 2);
        s = sda_line;
        wt(Q / 2);
        scl = 1'b0;
        wt(3);
    endtask : bit_c

    // MSB first, ninth bit is acknowledge
    task automatic byte_c(input logic [7:0] d, input logic ack_in, output logic [7:0] q,
                          output logic ack_seen);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_c(d[i], q[i]);
        end
        bit_c(ack_in, s);
        ack_seen = !s;
    endtask : byte_c

    // Only listed offsets, undefined bits left at zero
    task automatic wr(input logic [6:0] tgt, input logic [7:0] ra, input logic [7:0] d,
                      output logic ok);
        logic [7:0] q;
        logic       a0;
        logic       a1;
        logic       a2;
        start_c();
        byte_c({tgt, 1'b0}, 1'b1, q, a0);
        byte_c(ra, 1'b1, q, a1);
        byte_c(d, 1'b1, q, a2);
        stop_c();
        ok = a0 & a1 & a2;
    endtask : wr

    task automatic rd(input logic [6:0] tgt, input logic [7:0] ra, output logic [7:0] d);
        logic a;
        start_c();
        byte_c({tgt, 1'b0}, 1'b1, d, a);
        byte_c(ra, 1'b1, d, a);
        start_c();
        byte_c({tgt, 1'b1}, 1'b1, d, a);
        byte_c(8'hff, 1'b1, d, a);
        stop_c();
    endtask : rd

    // Two data bytes to consecutive registers
    task automatic wr2(input logic [6:0] tgt, input logic [7:0] ra, input logic [7:0] d0,
                       input logic [7:0] d1, output logic ok);
        logic [7:0] q;
        logic       a0;
        logic       a1;
        logic       a2;
        logic       a3;
        start_c();
        byte_c({tgt, 1'b0}, 1'b1, q, a0);
        byte_c(ra, 1'b1, q, a1);
        byte_c(d0, 1'b1, q, a2);
        byte_c(d1, 1'b1, q, a3);
        stop_c();
        ok = a0 & a1 & a2 & a3;
    endtask : wr2

    // Two bytes from consecutive registers, host acks the first
    task automatic rd2(input logic [6:0] tgt, input logic [7:0] ra, output logic [7:0] d0,
                       output logic [7:0] d1);
        logic a;
        start_c();
        byte_c({tgt, 1'b0}, 1'b1, d0, a);
        byte_c(ra, 1'b1, d0, a);
        start_c();
        byte_c({tgt, 1'b1}, 1'b1, d0, a);
        byte_c(8'hff, 1'b0, d0, a);
        byte_c(8'hff, 1'b1, d1, a);
        stop_c();
    endtask : rd2
endmodule : qpll_host

// ===== testbench.sv
/*
 Self-checking bench of the four-PLL front end: reset gating, PLL
 selection, map isolation and a foreign target address.
 Assumes qpll_host drives the serial pins.
*/
`include "qpll_map.svh"

module testbench;
    timeunit 1ns;
    timeprecision 100ps;

    logic       ref_clk;
    logic       reset;
    logic [3:0] pll_reset_n;
    logic       scl;
    logic       sda_pull;
    logic       sda_out;
    logic       sda_oe;
    logic [3:0] pll_lock_enable;
    logic [3:0] pll_free_run;
    logic [3:0] pll_bypass;
    logic [3:0] pll_freeze;
    logic       ok;
    logic [7:0] d;
    logic [7:0] d1;
    logic [7:0] runv [4];
    int         bad_count;
    int         n_checks;
    int         cycles;
    wire        sda_line = !(sda_pull | (sda_oe & !sda_out));

    qpll_i2c_top qpll_i2c_top_i (
        .ref_clk         (ref_clk),
        .reset           (reset),
        .scl_in          (scl),
        .sda_in          (sda_line),
        .sda_out         (sda_out),
        .sda_oe          (sda_oe),
        .pll_reset_n     (pll_reset_n),
        .pll_lock_enable (pll_lock_enable),
        .pll_free_run    (pll_free_run),
        .pll_bypass      (pll_bypass),
        .pll_freeze      (pll_freeze)
    );

    qpll_host qpll_host_i (
        .ref_clk  (ref_clk),
        .sda_line (sda_line),
        .scl      (scl),
        .sda_pull (sda_pull)
    );

    always #5 ref_clk = ~ref_clk;

    task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : chk8

    task automatic chk1(input string what, input logic exp, input logic got);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %s expected %b seen %b", what, exp, got);
        end
    endtask : chk1

    task automatic give_verdict;
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : give_verdict

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 40000) begin
            bad_count++;
            give_verdict();
        end
    end

    initial begin
        ref_clk = 1'b0;
        reset = 1'b1;
        pll_reset_n = 4'h0;
        bad_count = 0;
        n_checks = 0;
        cycles = 0;
        runv = '{8'h40, 8'h02, 8'h42, 8'h00};
        repeat (4) @(posedge ref_clk);
        #1 reset = 1'b0;
        qpll_host_i.wt(4);
        chk8("lock_enable", 8'h00, {4'h0, pll_lock_enable});
        pll_reset_n = 4'ha;
        qpll_host_i.wt(4);
        chk8("lock_enable", 8'h0a, {4'h0, pll_lock_enable});
        pll_reset_n = 4'hf;
        qpll_host_i.wt(4);
        chk8("lock_enable", 8'h0f, {4'h0, pll_lock_enable});
        chk1("sda_out", 1'b0, sda_out);
        $display("test reset_gating done");
        for (int s = 0; s < 4; s++) begin
            qpll_host_i.wr({`QPLL_ADDR_HI, 2'(s)}, `QPLL_RUN_CONTROL, runv[s], ok);
            chk1("write ack", 1'b1, ok);
        end
        chk8("free_run", 8'h05, {4'h0, pll_free_run});
        chk8("bypass", 8'h06, {4'h0, pll_bypass});
        for (int s = 0; s < 4; s++) begin
            qpll_host_i.rd({`QPLL_ADDR_HI, 2'(s)}, `QPLL_RUN_CONTROL, d);
            chk8("run_control", runv[s], d);
        end
        qpll_host_i.wr({`QPLL_ADDR_HI, 2'h3}, `QPLL_FREEZE_SQUELCH, 8'h20, ok);
        chk8("freeze", 8'h08, {4'h0, pll_freeze});
        qpll_host_i.rd({`QPLL_ADDR_HI, 2'h0}, `QPLL_FREEZE_SQUELCH, d);
        chk8("freeze_squelch_control", 8'h00, d);
        $display("test pll_select done");
        qpll_host_i.wr({5'h1b, 2'h0}, `QPLL_RUN_CONTROL, 8'h02, ok);
        chk1("foreign ack", 1'b0, ok);
        chk8("bypass", 8'h06, {4'h0, pll_bypass});
        qpll_host_i.rd({`QPLL_ADDR_HI, 2'h0}, `QPLL_RUN_CONTROL, d);
        chk8("run_control", 8'h40, d);
        $display("test foreign_address done");
        qpll_host_i.wr2({`QPLL_ADDR_HI, 2'h1}, `QPLL_FINE_LATENCY_HIGH, 8'h5a, 8'ha5, ok);
        chk1("burst ack", 1'b1, ok);
        qpll_host_i.rd2({`QPLL_ADDR_HI, 2'h1}, `QPLL_FINE_LATENCY_HIGH, d, d1);
        chk8("fine_latency_high", 8'h5a, d);
        chk8("fine_latency_low", 8'ha5, d1);
        qpll_host_i.rd({`QPLL_ADDR_HI, 2'h2}, `QPLL_FINE_LATENCY_LOW, d);
        chk8("fine_latency_low", 8'h00, d);
        $display("test burst done");
        reset = 1'b1;
        qpll_host_i.wt(2);
        reset = 1'b0;
        qpll_host_i.wt(4);
        chk8("free_run", 8'h00, {4'h0, pll_free_run});
        qpll_host_i.rd({`QPLL_ADDR_HI, 2'h2}, `QPLL_RUN_CONTROL, d);
        chk8("run_control", 8'h00, d);
        $display("test mid_reset done");
        give_verdict();
    end
endmodule : testbench
